// [pkg/sfwc_params.svh]
// Function
// RL1: serial bus modes 0 and 3 both work; clock idles low or high.
// RL2: incoming bits are sampled on every rising serial clock edge.
// RL3: dual read opcodes turn lines zero and one into two data lines.
// RL4: quad read opcode uses four data lines, protect and pause pins included.
// RL5: full-quad enter opcode switches to four-line mode for whole sequences.
// RL6: host sends write enable, then opcode, three address bytes and data.
// RL7: one program sequence covers at most 256 bytes within one page.
// RL8: erase works per sector, half block, block or whole array.
// RL9: host issues write enable before every erase or nothing starts.
// RL10: busy flag stays one during status write, program and erase cycles.
// RL11: deselected device stays active until internal cycles end, then standby.
// RL12: in deep sleep only the wake and id opcode is obeyed; the core still drives read opcode data on the link side.
// RL13: four protect select bits pick the region refusing program and erase.
// RL14: protect codes map to upper or lower block counts, or none, or all.
// RL15: pin disable bit at one turns off protect and pause pin functions.
// RL16: status protect flag with protect pin low locks protect bits.
// RL17: in secure mode a status write only sets the lock bit.
// RL18: lock bit never clears; locked secure sector refuses program and erase.
// RL19: erase suspended flag sets on erase suspend, clears on resume.
// RL20: program suspended flag sets on program suspend, clears on resume.
// RL21: modifying opcodes need a clock pulse count that is a multiple of eight.
// RL22: write enable latch set by write enable, cleared on completions.
// RL23: pause pin low tri-states output and freezes input in narrow modes.
// RL24: opcode first, then address and data, most significant bit first.
// RL25: protected targets or a clear write enable latch skip the operation.
// RL26: data-modifying opcodes are blocked until the power-up timer expires.
`ifndef SFWC_PARAMS_SVH
`define SFWC_PARAMS_SVH
`define SF_C_STWR   8'h01
`define SF_C_PGM    8'h02
`define SF_C_RD     8'h03
`define SF_C_WDIS   8'h04
`define SF_C_RSTAT  8'h05
`define SF_C_WENA   8'h06
`define SF_C_RSUSP  8'h09
`define SF_C_FRD    8'h0b
`define SF_C_SECT   8'h20
`define SF_C_RESUME 8'h30
`define SF_C_QPGM   8'h32
`define SF_C_FQON   8'h38
`define SF_C_OTP    8'h3a
`define SF_C_DOUT   8'h3b
`define SF_C_HALF   8'h52
`define SF_C_CHIP1  8'h60
`define SF_C_CHIP2  8'hc7
`define SF_C_WAKE   8'hab
`define SF_C_SUSP   8'hb0
`define SF_C_SLEEP  8'hb9
`define SF_C_DIO    8'hbb
`define SF_C_BLK    8'hd8
`define SF_C_QIO    8'heb
`define SF_C_FQOFF  8'hff
`define SF_B_BUSY   0
`define SF_B_WEL    1
`define SF_B_BP     2
`define SF_B_PDIS   6
`define SF_B_SPROT  7
`define SF_B_ESUS   2
`define SF_B_PSUS   3
`define SF_N_OPC    12'h008
`define SF_N_STW    12'h010
`define SF_N_ADR    12'h020
`define SF_N_PGM    12'h028
`define SF_N_QRD    12'h038
`define SF_N_MAX    12'hff0
`define SF_PAGE     9'h100
`define SF_BP_RST   4'h0
`define SF_PDIS_RST 1'b0
`define SF_SPROT_RST 1'b0
`define SF_CLK_MHZ  10
`define SF_TPUW_US  10
`endif

// [pkg/sfwc_pkg.sv]
package sfwc_pkg;
  typedef enum logic [2:0] {
    sfwc_op_none = 3'b000,
    sfwc_op_stwr = 3'b001,
    sfwc_op_prog = 3'b010,
    sfwc_op_sect = 3'b011,
    sfwc_op_half = 3'b100,
    sfwc_op_blk  = 3'b101,
    sfwc_op_chip = 3'b110
  } sfwc_op_t;
  typedef enum logic [1:0] {
    sfwc_pwr_standby = 2'b00,
    sfwc_pwr_active  = 2'b01,
    sfwc_pwr_deep    = 2'b10
  } sfwc_pwr_t;
endpackage

// [src/sfwc_core.sv]
`timescale 1ns/100ps
`include "sfwc_params.svh"
module sfwc_core
  import sfwc_pkg::*;
#(
  parameter int        W_CYC   = 1000,
  parameter int        PP_CYC  = 1000,
  parameter int        ER_CYC  = 2000,
  parameter int        CE_CYC  = 4000,
  parameter logic [7:0] ID_CODE = 8'h5a  // arbitrary value
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n,
  // array read data, link clock side
  input  wire logic [7:0]  rd_byte,
  // array operation request
  output logic             op_start,
  output sfwc_op_t         op_kind,
  output logic      [23:0] op_addr,
  output logic      [8:0]  op_len,
  output logic             op_secure,
  output logic             op_done,
  // state
  output sfwc_pwr_t        power_mode,
  output logic [7:0]       status_out,
  output logic [7:0]       suspend_out
);
  localparam int PUW_CYC = `SF_TPUW_US * `SF_CLK_MHZ;

  // ---------------- link clock domain ----------------
  logic        fresh_reg;
  logic [11:0] nbits_reg;
  logic [2:0]  pcnt_reg;
  logic [31:0] sr_reg;
  logic [7:0]  opc_reg;
  logic [23:0] addr_reg;
  logic [7:0]  sdat_reg;
  logic [16:0] st_l1_reg;
  logic [16:0] st_l2_reg;
  logic [7:0]  osh_reg;
  logic        odrv_reg;
  logic [11:0] nb_cur;
  logic [11:0] nbits_next;
  logic [31:0] sr_next;
  logic [2:0]  lane_w;
  logic [2:0]  out_w;
  logic        out_on;
  logic [7:0]  out_src;
  logic [7:0]  osh_next;
  logic        fq_l;
  logic        hold_act;
  logic        quad_op;
  logic        fq_reg;

  // level crossing of status bits, one bit each
  always_ff @(posedge sclk) begin
    st_l1_reg <= {fq_reg, suspend_out, status_out};
    st_l2_reg <= st_l1_reg;
  end
  assign fq_l = st_l2_reg[16];

  // pause pin is data in quad use
  assign quad_op = fq_l || (!fresh_reg && nbits_reg >= `SF_N_OPC &&
                   (opc_reg == `SF_C_QIO || opc_reg == `SF_C_QPGM));
  // RL23 pause pin freeze
  assign hold_act = !io_in[3] && !st_l2_reg[`SF_B_PDIS] && !quad_op;

  assign nb_cur = fresh_reg ? 12'h000 : nbits_reg;

  // RL3 RL4 RL5 lane width
  always_comb begin
    lane_w = fq_l ? 3'd4 : 3'd1;
    if (!fq_l && nb_cur >= `SF_N_OPC) begin
      unique case (opc_reg)
        `SF_C_DIO:  lane_w = 3'd2;
        `SF_C_QIO:  lane_w = 3'd4;
        `SF_C_QPGM: lane_w = (nb_cur >= `SF_N_ADR) ? 3'd4 : 3'd1;
        default:    lane_w = 3'd1;
      endcase
    end
  end

  // RL24 msb first shift
  always_comb begin
    unique case (lane_w)
      3'd4:    sr_next = {sr_reg[27:0], io_in};
      3'd2:    sr_next = {sr_reg[29:0], io_in[1:0]};
      default: sr_next = {sr_reg[30:0], io_in[0]};
    endcase
    nbits_next = (nb_cur < `SF_N_MAX) ? nb_cur + {9'h000, lane_w} : nb_cur;
  end

  // RL1 frame start by select, not by clock level
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_reg <= 1'b1;
    end else if (!hold_act) begin
      fresh_reg <= 1'b0;
    end
  end

  // RL2 rising edge sampling
  always_ff @(posedge sclk) begin
    if (!cs_n && !hold_act) begin
      sr_reg    <= sr_next;
      nbits_reg <= nbits_next;
      pcnt_reg  <= fresh_reg ? 3'd1 : pcnt_reg + 3'd1;
      if (nbits_next == `SF_N_OPC) begin
        opc_reg <= sr_next[7:0];
      end
      if (nbits_next == `SF_N_STW) begin
        sdat_reg <= sr_next[7:0];
      end
      if (nbits_next == `SF_N_ADR) begin
        addr_reg <= sr_next[23:0];
      end
    end
  end

  // output phase and source
  always_comb begin
    out_on  = 1'b0;
    out_src = rd_byte;
    out_w   = fq_l ? 3'd4 : 3'd1;
    unique case (opc_reg)
      `SF_C_RSTAT: begin
        out_on  = nbits_reg >= `SF_N_OPC;
        out_src = st_l2_reg[7:0];
      end
      `SF_C_RSUSP: begin
        out_on  = nbits_reg >= `SF_N_OPC;
        out_src = st_l2_reg[15:8];
      end
      `SF_C_WAKE: begin
        out_on  = nbits_reg >= `SF_N_ADR;
        out_src = ID_CODE;
      end
      `SF_C_RD:  out_on = nbits_reg >= `SF_N_ADR;
      `SF_C_FRD: out_on = nbits_reg >= `SF_N_PGM;
      `SF_C_DOUT, `SF_C_DIO: begin
        out_on = nbits_reg >= `SF_N_PGM;
        out_w  = fq_l ? 3'd4 : 3'd2;
      end
      `SF_C_QIO: begin
        out_on = nbits_reg >= `SF_N_QRD;
        out_w  = 3'd4;
      end
      default: out_on = 1'b0;
    endcase
    if (fresh_reg || nbits_reg < `SF_N_OPC) begin
      out_on = 1'b0;
    end
    if (nbits_reg[2:0] == 3'd0) begin
      osh_next = out_src;
    end else if (out_w == 3'd4) begin
      osh_next = {osh_reg[3:0], 4'h0};
    end else if (out_w == 3'd2) begin
      osh_next = {osh_reg[5:0], 2'b00};
    end else begin
      osh_next = {osh_reg[6:0], 1'b0};
    end
  end

  // output shifts on falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      osh_reg  <= 8'h00;
      odrv_reg <= 1'b0;
      io_out   <= 4'h0;
    end else if (!hold_act) begin
      odrv_reg <= out_on;
      osh_reg  <= osh_next;
      if (out_w == 3'd4) begin
        io_out <= osh_next[7:4];
      end else if (out_w == 3'd2) begin
        io_out <= {2'b00, osh_next[7:6]};
      end else begin
        io_out <= {2'b00, osh_next[7], 1'b0};
      end
    end
  end

  // RL3 RL23 line drive enables
  always_comb begin
    io_oe_n = 4'hf;
    if (!cs_n && odrv_reg && !hold_act) begin
      if (out_w == 3'd4) begin
        io_oe_n = 4'h0;
      end else if (out_w == 3'd2) begin
        io_oe_n = 4'hc;
      end else begin
        io_oe_n = 4'hd;
      end
    end
  end

  // ---------------- system clock domain ----------------
  logic        cs_s1, cs_s2, cs_s3;
  logic        fr_s1, fr_s2, fr_s3;
  logic        wp_s1, wp_s2;
  logic        end_evt;
  logic        wip_reg, wel_reg, pdis_reg, sprot_reg, lock_reg;
  logic [3:0]  bp_reg;
  logic        esus_reg, psus_reg, deep_reg, otp_reg;
  logic        puw_done;
  logic [15:0] puw_cnt;
  logic [23:0] busy_cnt;
  logic        busy_end;
  logic        ok8, mod_ok, hw_prot, prot_addr, prot_any;
  logic [3:0]  pcount;
  logic        pupper;
  logic [8:0]  bytes;
  sfwc_op_t    acc_op;
  logic        acc_wena, acc_wdis, acc_sleep, acc_wake;
  logic        acc_susp, acc_res, acc_fqon, acc_fqoff, acc_otp;

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      fr_s1 <= 1'b1;
      fr_s2 <= 1'b1;
      fr_s3 <= 1'b1;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      // frame marker rides beside select; deselect sets it at once
      fr_s1 <= fresh_reg;
      fr_s2 <= fr_s1;
      fr_s3 <= fr_s2;
      wp_s1 <= io_in[2];
      wp_s2 <= wp_s1;
    end
  end
  assign end_evt = cs_s2 && !cs_s3;

  // RL26 power-up write timer
  always_ff @(posedge clk) begin
    if (rst) begin
      puw_cnt  <= 16'h0000;
      puw_done <= 1'b0;
    end else if (!puw_done) begin
      puw_cnt  <= puw_cnt + 16'h0001;
      puw_done <= (puw_cnt == 16'(PUW_CYC - 1));
    end
  end

  // RL14 protect code decode
  always_comb begin
    pupper = !bp_reg[3];
    unique case (bp_reg[2:0])
      3'd0:    pcount = 4'd0;
      3'd1:    pcount = 4'd1;
      3'd2:    pcount = 4'd2;
      3'd3:    pcount = 4'd4;
      3'd4:    pcount = 4'd6;
      3'd5:    pcount = 4'd7;
      default: pcount = 4'd8;
    endcase
  end
  // RL13 region check on 64k block index
  assign prot_addr = pupper ? ({1'b0, addr_reg[18:16]} >= 4'd8 - pcount)
                            : ({1'b0, addr_reg[18:16]} < pcount);
  assign prot_any = pcount != 4'd0;
  // RL15 RL16 hardware protect
  assign hw_prot = sprot_reg && !wp_s2 && !pdis_reg;
  // RL21 clock pulse count check
  assign ok8 = pcnt_reg == 3'd0;
  // RL25 RL26 gate for modifying opcodes
  assign mod_ok = ok8 && wel_reg && puw_done && !wip_reg && !deep_reg &&
                  !esus_reg && !psus_reg;
  assign bytes = 9'((nbits_reg - `SF_N_ADR) >> 3);

  // decision at end of frame
  always_comb begin
    acc_op    = sfwc_op_none;
    acc_wena  = 1'b0;
    acc_wdis  = 1'b0;
    acc_sleep = 1'b0;
    acc_wake  = 1'b0;
    acc_susp  = 1'b0;
    acc_res   = 1'b0;
    acc_fqon  = 1'b0;
    acc_fqoff = 1'b0;
    acc_otp   = 1'b0;
    if (end_evt && !fr_s3 && nbits_reg >= `SF_N_OPC) begin
      if (deep_reg) begin
        // RL12 only wake is obeyed
        acc_wake = opc_reg == `SF_C_WAKE;
      end else begin
        unique case (opc_reg)
          // RL22 latch set and clear
          `SF_C_WENA:  acc_wena = ok8 && !wip_reg &&
                                  nbits_reg == `SF_N_OPC;
          `SF_C_WDIS:  acc_wdis = ok8 && !wip_reg &&
                                  nbits_reg == `SF_N_OPC;
          `SF_C_STWR:
            if (mod_ok && nbits_reg == `SF_N_STW) begin
              acc_op = sfwc_op_stwr;
            end
          // RL7 RL25 program acceptance
          `SF_C_PGM, `SF_C_QPGM:
            if (mod_ok && nbits_reg >= `SF_N_PGM &&
                (otp_reg ? !lock_reg : !prot_addr)) begin
              acc_op = sfwc_op_prog;
            end
          // RL8 RL18 erase acceptance
          `SF_C_SECT:
            if (mod_ok && nbits_reg == `SF_N_ADR &&
                (otp_reg ? !lock_reg : !prot_addr)) begin
              acc_op = sfwc_op_sect;
            end
          `SF_C_HALF:
            if (mod_ok && nbits_reg == `SF_N_ADR && !otp_reg &&
                !prot_addr) begin
              acc_op = sfwc_op_half;
            end
          `SF_C_BLK:
            if (mod_ok && nbits_reg == `SF_N_ADR && !otp_reg &&
                !prot_addr) begin
              acc_op = sfwc_op_blk;
            end
          `SF_C_CHIP1, `SF_C_CHIP2:
            if (mod_ok && nbits_reg == `SF_N_OPC && !otp_reg &&
                !prot_any) begin
              acc_op = sfwc_op_chip;
            end
          `SF_C_SLEEP: acc_sleep = ok8 && !wip_reg;
          `SF_C_SUSP:  acc_susp = wip_reg && op_kind != sfwc_op_stwr &&
                                  op_kind != sfwc_op_chip;
          `SF_C_RESUME: acc_res = esus_reg || psus_reg;
          // RL5 four-line mode entry and exit
          `SF_C_FQON:  acc_fqon = !wip_reg;
          `SF_C_FQOFF: acc_fqoff = 1'b1;
          `SF_C_OTP:   acc_otp = !wip_reg;
          default:     acc_op = sfwc_op_none;
        endcase
      end
    end
  end

  // request to the array
  always_ff @(posedge clk) begin
    if (rst) begin
      op_start  <= 1'b0;
      op_kind   <= sfwc_op_none;
      op_addr   <= 24'h000000;
      op_len    <= 9'h000;
      op_secure <= 1'b0;
    end else begin
      op_start <= acc_op != sfwc_op_none;
      if (acc_op != sfwc_op_none) begin
        op_kind   <= acc_op;
        op_addr   <= addr_reg;
        op_secure <= otp_reg;
        // RL7 page length cap
        op_len    <= (bytes > `SF_PAGE) ? `SF_PAGE : bytes;
      end
    end
  end

  // RL10 busy flag and cycle timer
  assign busy_end = wip_reg && busy_cnt == 24'h000001;
  always_ff @(posedge clk) begin
    if (rst) begin
      wip_reg  <= 1'b0;
      busy_cnt <= 24'h000000;
      op_done  <= 1'b0;
    end else begin
      op_done <= busy_end;
      if (acc_op != sfwc_op_none) begin
        wip_reg <= 1'b1;
        unique case (acc_op)
          sfwc_op_stwr: busy_cnt <= 24'(W_CYC);
          sfwc_op_prog: busy_cnt <= 24'(PP_CYC);
          sfwc_op_chip: busy_cnt <= 24'(CE_CYC);
          default:      busy_cnt <= 24'(ER_CYC);
        endcase
      end else if (acc_susp) begin
        wip_reg <= 1'b0;
      end else if (acc_res) begin
        wip_reg <= 1'b1;
      end else if (busy_end) begin
        wip_reg  <= 1'b0;
        busy_cnt <= 24'h000000;
      end else if (wip_reg) begin
        busy_cnt <= busy_cnt - 24'h000001;
      end
    end
  end

  // RL19 RL20 suspend flags
  always_ff @(posedge clk) begin
    if (rst) begin
      esus_reg <= 1'b0;
      psus_reg <= 1'b0;
    end else if (acc_susp) begin
      esus_reg <= op_kind != sfwc_op_prog;
      psus_reg <= op_kind == sfwc_op_prog;
    end else if (acc_res) begin
      esus_reg <= 1'b0;
      psus_reg <= 1'b0;
    end
  end

  // RL22 write enable latch
  always_ff @(posedge clk) begin
    if (rst) begin
      wel_reg <= 1'b0;
    end else if (acc_wena) begin
      wel_reg <= 1'b1;
    end else if (acc_wdis || busy_end) begin
      wel_reg <= 1'b0;
    end
  end

  // RL13 RL16 RL17 protect bits and lock
  always_ff @(posedge clk) begin
    if (rst) begin
      bp_reg    <= `SF_BP_RST;
      pdis_reg  <= `SF_PDIS_RST;
      sprot_reg <= `SF_SPROT_RST;
      lock_reg  <= 1'b0;
    end else if (acc_op == sfwc_op_stwr) begin
      if (otp_reg) begin
        lock_reg <= 1'b1;
      end else begin
        pdis_reg <= sdat_reg[`SF_B_PDIS];
        if (!hw_prot) begin
          bp_reg    <= sdat_reg[`SF_B_BP +: 4];
          sprot_reg <= sdat_reg[`SF_B_SPROT];
        end
      end
    end
  end

  // RL12 deep sleep, RL5 quad mode, secure mode
  always_ff @(posedge clk) begin
    if (rst) begin
      deep_reg <= 1'b0;
      fq_reg   <= 1'b0;
      otp_reg  <= 1'b0;
    end else begin
      if (acc_sleep) begin
        deep_reg <= 1'b1;
      end else if (acc_wake) begin
        deep_reg <= 1'b0;
      end
      if (acc_fqon) begin
        fq_reg <= 1'b1;
      end else if (acc_fqoff) begin
        fq_reg <= 1'b0;
      end
      if (acc_otp) begin
        otp_reg <= 1'b1;
      end else if (acc_wdis) begin
        otp_reg <= 1'b0;
      end
    end
  end

  // RL11 power mode
  always_ff @(posedge clk) begin
    if (rst) begin
      power_mode <= sfwc_pwr_standby;
    end else if (deep_reg) begin
      power_mode <= sfwc_pwr_deep;
    end else if (!cs_s2 || wip_reg) begin
      power_mode <= sfwc_pwr_active;
    end else begin
      power_mode <= sfwc_pwr_standby;
    end
  end

  // lock bit shows in place of status protect in secure mode
  assign status_out = {otp_reg ? lock_reg : sprot_reg, pdis_reg, bp_reg,
                       wel_reg, wip_reg};
  assign suspend_out = {4'h0, psus_reg, esus_reg, 2'b00};

  a_busy_after_start:
    assert property (@(posedge clk) disable iff (rst) // RL10
      op_start |-> wip_reg) else $error("busy low after start");
  a_wel_needed:
    assert property (@(posedge clk) disable iff (rst) // RL25
      op_start |-> $past(wel_reg)) else $error("op without latch");
  a_wel_clear_end:
    assert property (@(posedge clk) disable iff (rst) // RL22
      busy_end |=> !wel_reg && !wip_reg) else $error("latch kept");
  a_deep_ignore:
    assert property (@(posedge clk) disable iff (rst) // RL12
      deep_reg && !acc_wake |=> deep_reg && !op_start)
      else $error("deep sleep left");
  a_lock_sticky:
    assert property (@(posedge clk) disable iff (rst) // RL18
      lock_reg |=> lock_reg) else $error("lock cleared");
  a_puw_block:
    assert property (@(posedge clk) disable iff (rst) // RL26
      !$past(puw_done) |-> !op_start) else $error("op before timer");
  a_len_cap:
    assert property (@(posedge clk) disable iff (rst) // RL7
      op_start && op_kind == sfwc_op_prog |-> op_len <= 9'h100 &&
      op_len != 9'h000) else $error("bad page length");
  a_erase_susp:
    assert property (@(posedge clk) disable iff (rst) // RL19
      acc_susp && op_kind != sfwc_op_prog |=> esus_reg && !wip_reg)
      else $error("erase suspend flag");
  a_hw_lock_bp:
    assert property (@(posedge clk) disable iff (rst) // RL16
      hw_prot && !otp_reg |=> $stable(bp_reg) && sprot_reg)
      else $error("protect bits changed");
  a_bits_mult8:
    assert property (@(posedge clk) disable iff (rst) // RL21
      acc_op != sfwc_op_none |-> pcnt_reg == 3'd0)
      else $error("odd pulse count");
endmodule

// [tb/sfwc_host.sv]
`timescale 1ns/100ps
module sfwc_host (
  // serial pins
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out
);
  logic       mode3;
  logic [7:0] rx;
  initial begin
    mode3 = 1'b0;
    sclk  = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'hf;
    rx    = 8'h00;
  end
  task automatic xfer(input logic [39:0] d, input int nb);
    cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      #62.5;
      sclk     <= 1'b0;
      io_in[0] <= d[39-i];
      #62.5;
      sclk <= 1'b1;
      rx   <= {rx[6:0], io_out[1]};
    end
    #62.5;
    sclk     <= mode3;
    io_in[0] <= ~io_in[0];
    #62.5;
    cs_n <= 1'b1;
    // gap longer than five clocks between frames
    #700;
  endtask
endmodule

// [tb/sfwc_bench.sv]
`timescale 1ns/100ps
`include "sfwc_params.svh"
module sfwc_bench;
  import sfwc_pkg::*;
  typedef struct {
    logic [7:0]  opc;
    logic [23:0] adr;
    int          nb;
    logic        write_enable_latch;
    logic        go;
    sfwc_op_t    kind;
  } sfwc_row_t;
  logic        clk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_n;
  logic        op_start;
  sfwc_op_t    op_kind;
  logic [23:0] op_addr;
  logic [8:0]  op_len;
  logic        op_done;
  int          dones;
  sfwc_pwr_t   power_mode;
  logic [7:0]  status_out;
  logic [7:0]  suspend_out;
  int          errors;
  int          comparisons;
  int          starts;
  sfwc_row_t   rows[16];
  sfwc_core #(.W_CYC(40), .PP_CYC(40), .ER_CYC(40), .CE_CYC(40),
    .ID_CODE(8'h3c)) dut (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .rd_byte(8'ha5),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .op_len(op_len), .op_secure(), .op_done(op_done),
    .power_mode(power_mode),
    .status_out(status_out), .suspend_out(suspend_out));
  sfwc_host host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (op_done === 1'b1) begin
      dones <= dones + 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 200 && status_out[0] !== 1'b0; n++) begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic run(input sfwc_row_t r);
    int s0;
    s0 = starts;
    if (r.write_enable_latch) begin
      host.xfer({`SF_C_WENA, 32'h0}, 8);
    end
    host.xfer({r.opc, r.adr, 8'h00}, r.nb);
    repeat (8) @(posedge clk);
    chk("op_start", {7'h0, r.go}, 8'(starts - s0));
    if (r.go) begin
      chk("op_kind", {5'h0, r.kind}, {5'h0, op_kind});
      if (r.nb >= 32) begin
        chk("op_addr", r.adr[19:12], op_addr[19:12]);
      end
      if (r.kind == sfwc_op_prog) begin
        chk("op_len", 8'h01, op_len[7:0]);
      end
    end
    wait_idle();
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // power-up write timer must run out first
    repeat (120) @(posedge clk);
  endtask
  task report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    errors = 0;
    comparisons = 0;
    starts = 0;
    dones = 0;
    // data byte of a status write rides in adr[23:16]
    rows = '{
      '{`SF_C_SECT, 24'h001000, 32, 1, 1, sfwc_op_sect},
      '{`SF_C_SECT, 24'h001000, 32, 0, 0, sfwc_op_none},
      '{`SF_C_HALF, 24'h008000, 32, 1, 1, sfwc_op_half},
      '{`SF_C_BLK, 24'h010000, 32, 1, 1, sfwc_op_blk},
      '{`SF_C_CHIP1, 24'h0, 8, 1, 1, sfwc_op_chip},
      '{`SF_C_CHIP2, 24'h0, 8, 1, 1, sfwc_op_chip},
      '{`SF_C_PGM, 24'h0200ff, 40, 1, 1, sfwc_op_prog},
      '{`SF_C_SECT, 24'h001000, 31, 1, 0, sfwc_op_none},
      '{`SF_C_WDIS, 24'h0, 8, 0, 0, sfwc_op_none},
      '{`SF_C_SECT, 24'h001000, 32, 0, 0, sfwc_op_none},
      '{`SF_C_STWR, 24'h040000, 16, 1, 1, sfwc_op_stwr},
      '{`SF_C_SECT, 24'h070000, 32, 1, 0, sfwc_op_none},
      '{`SF_C_SECT, 24'h060000, 32, 1, 1, sfwc_op_sect},
      '{`SF_C_STWR, 24'h240000, 16, 1, 1, sfwc_op_stwr},
      '{`SF_C_SECT, 24'h000000, 32, 1, 0, sfwc_op_none},
      '{`SF_C_SECT, 24'h070000, 32, 1, 1, sfwc_op_sect}};
    do_reset();
    for (int i = 0; i < 16; i++) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    run(rows[10]);
    host.xfer({`SF_C_RSTAT, 32'h0}, 16);
    chk("status_read", 8'h04, host.rx);
    chk("oe_idle", 8'h0f, {4'h0, io_oe_n});
    // busy and latch held through the cycle, then both drop
    host.xfer({`SF_C_WENA, 32'h0}, 8);
    // upper block is protected now, so erase a low sector
    host.xfer({`SF_C_SECT, 24'h001000, 8'h00}, 32);
    chk("status_busy", 8'h07, status_out);
    chk("power_busy", {6'h0, sfwc_pwr_active}, {6'h0, power_mode});
    wait_idle();
    chk("status_done", 8'h04, status_out);
    chk("power_idle", {6'h0, sfwc_pwr_standby}, {6'h0, power_mode});
    $display("busy test done");
    host.xfer({`SF_C_WENA, 32'h0}, 8);
    host.xfer({`SF_C_BLK, 24'h020000, 8'h00}, 32);
    host.xfer({`SF_C_SUSP, 32'h0}, 8);
    chk("suspend_set", 8'h04, suspend_out);
    host.xfer({`SF_C_RESUME, 32'h0}, 8);
    chk("suspend_clr", 8'h00, suspend_out);
    wait_idle();
    $display("suspend test done");
    host.xfer({`SF_C_SLEEP, 32'h0}, 8);
    chk("power_deep", {6'h0, sfwc_pwr_deep}, {6'h0, power_mode});
    rows[1].write_enable_latch = 1'b1;
    run(rows[1]);
    host.xfer({`SF_C_WAKE, 32'h0}, 40);
    chk("wake_id", 8'h3c, host.rx);
    chk("power_wake", {6'h0, sfwc_pwr_standby}, {6'h0, power_mode});
    $display("deep sleep test done");
    // mode change only while the part is held in reset
    rst <= 1'b1;
    host.mode3 <= 1'b1;
    host.sclk <= 1'b1;
    repeat (2) @(posedge clk);
    chk("status_rst", 8'h00, status_out);
    do_reset();
    run(rows[0]);
    $display("mode 3 test done");
    chk("op_done", 8'(starts), 8'(dones));
    report_and_stop();
  end
endmodule
